// ==== rtl/cfsr_cfg.svh ====
`ifndef CFSR_CFG_SVH
`define CFSR_CFG_SVH
// register indices, byte address is four times the index
`define CFSR_IDX_INDIRECT    10'h000
`define CFSR_IDX_PC_LOW      10'h002
`define CFSR_IDX_BANK_CTRL   10'h003
`define CFSR_IDX_FILE_PTR    10'h004
`define CFSR_IDX_PC_LATCH    10'h00A
`define CFSR_IDX_FLAGS       10'h00C
`define CFSR_IDX_POWER       10'h08E
// event flag field positions
`define CFSR_BIT_EEPROM      7
`define CFSR_BIT_COMPARATOR  6
`define CFSR_BIT_SERIAL_RX   5
`define CFSR_BIT_SERIAL_TX   4
`define CFSR_BIT_CCP         2
`define CFSR_BIT_TIMER2      1
`define CFSR_BIT_TIMER1      0
`define CFSR_FLAGS_WMASK     8'hC7
// power control and bank control field positions
`define CFSR_BIT_OSC_SPEED   3
`define CFSR_BIT_POWER_ON    1
`define CFSR_BIT_BROWN_OUT   0
`define CFSR_BIT_BANK        7
// reset values, interrupt vector and storage sizes
`define CFSR_FLAGS_RESET     8'h00
`define CFSR_OSC_RESET       1'b1
`define CFSR_PC_RESET        13'h0000
`define CFSR_IRQ_VECTOR      13'h0004
`define CFSR_STACK_DEPTH     8
`define CFSR_DATA_WORDS      512
`endif

// ==== rtl/cfsr_pkg.sv ====
`default_nettype none
package cfsr_pkg;
    typedef enum logic [1:0] {
        CFSR_CCP_OFF     = 2'b00,
        CFSR_CCP_CAPTURE = 2'b01,
        CFSR_CCP_COMPARE = 2'b10,
        CFSR_CCP_PWM     = 2'b11
    } cfsr_ccp_mode_t;
    typedef logic [12:0] cfsr_pc_t;
    typedef logic [2:0]  cfsr_sp_t;
endpackage : cfsr_pkg
`default_nettype wire

// ==== rtl/cfsr_regs.sv ====
// Functional notes
// - each event flag sets on its event regardless of any enable
// - bit 7 sets when eeprom write finishes, stays until software clears
// - bit 6 sets whenever comparator output changes
// - bit 5 read-only, reads 1 while receive buffer holds data
// - bit 4 read-only, reads 1 while transmit buffer is empty
// - bit 2 sets on capture or compare match by mode, unused in pwm
// - bit 1 sets on timer 2 period match, stays until cleared
// - bit 0 sets on timer 1 overflow, stays until cleared
// - oscillator speed bit resets to 1: 1 fast, 0 slow
// - power-on bit cleared by power-on reset, stays 0 until written 1
// - brown-out bit cleared by brown-out reset, software sets it
// - brown-out bit meaningless when brown-out circuit disabled
// - program counter is 13 bits, only low byte software visible
// - every reset clears the whole program counter
// - low byte write copies latch bits 4..0 into upper bits
// - call and jump take upper two bits from latch bits 4..3
// - return stack holds eight 13-bit entries, pointer hidden
// - push on call or interrupt, pop on any return, latch untouched
// - stack wraps circularly, no overflow or underflow status
// - indirect port accesses the location the file pointer selects
// - indirect access to the port itself reads 00h, writes nothing
// - indirect address is bank bit above the 8-bit file pointer
`include "cfsr_cfg.svh"
`default_nettype none
module cfsr_regs
    import cfsr_pkg::*;
(
    // clock and reset
    input  wire logic           pclk,
    input  wire logic           presetn,
    // apb slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [11:0]    paddr,
    input  wire logic [31:0]    pwdata,
    output logic                pready,
    output logic [31:0]         prdata,
    output logic                pslverr,
    // reset cause and configuration
    input  wire logic           reset_was_por,
    input  wire logic           reset_was_bor,
    input  wire logic           brown_out_enable_config,
    // peripheral events
    input  wire logic           eeprom_write_done,
    input  wire logic           comparator_out,
    input  wire logic           rx_buffer_full,
    input  wire logic           tx_buffer_empty,
    input  wire cfsr_ccp_mode_t ccp_mode,
    input  wire logic           ccp_capture,
    input  wire logic           ccp_compare_match,
    input  wire logic           timer2_match,
    input  wire logic           timer1_overflow,
    // instruction core
    input  wire logic           pc_advance,
    input  wire logic           jump_call,
    input  wire logic           jump_goto,
    input  wire logic [10:0]    jump_target,
    input  wire logic           irq_branch,
    input  wire logic           return_any,
    // status outputs
    output cfsr_pc_t            program_counter,
    output logic                internal_osc_speed_select,
    output logic [7:0]          peripheral_event_flags
);

    function automatic logic set_wins(input logic cur, input logic wr,
                                      input logic wval, input logic ev);
        set_wins = (wr ? wval : cur) | ev;
    endfunction : set_wins

    // storage
    logic [7:0]  program_counter_high_latch;
    logic [7:0]  file_pointer;
    logic        indirect_bank_bit;
    logic        power_on_status;
    logic        brown_out_status;
    logic        cause_pending;
    logic        comparator_prev;
    cfsr_sp_t    stack_ptr;
    cfsr_pc_t    return_stack [`CFSR_STACK_DEPTH];
    logic [7:0]  data_mem [`CFSR_DATA_WORDS];

    // bus decode
    wire logic [9:0] reg_idx    = paddr[11:2];
    wire logic       bus_access = psel & penable;
    wire logic       bus_fire   = bus_access & pready;
    wire logic       wr_fire    = bus_fire & pwrite;
    wire logic       hit_ind    = reg_idx == `CFSR_IDX_INDIRECT;
    wire logic       hit_pcl    = reg_idx == `CFSR_IDX_PC_LOW;
    wire logic       hit_bank   = reg_idx == `CFSR_IDX_BANK_CTRL;
    wire logic       hit_fsr    = reg_idx == `CFSR_IDX_FILE_PTR;
    wire logic       hit_latch  = reg_idx == `CFSR_IDX_PC_LATCH;
    wire logic       hit_flags  = reg_idx == `CFSR_IDX_FLAGS;
    wire logic       hit_power  = reg_idx == `CFSR_IDX_POWER;
    wire logic       hit_any    = hit_ind | hit_pcl | hit_bank | hit_fsr
                                | hit_latch | hit_flags | hit_power;
    wire logic       wr_flags   = wr_fire & hit_flags;
    wire logic       wr_power   = wr_fire & hit_power;
    wire logic       wr_pcl     = wr_fire & hit_pcl;
    wire logic [7:0] wbyte      = pwdata[7:0];

    // indirect addressing
    wire logic [8:0] ind_addr   = {indirect_bank_bit, file_pointer};
    wire logic       ind_self   = ind_addr[6:0] == 7'h00;
    wire logic [7:0] ind_rdata  = ind_self ? 8'h00 : data_mem[ind_addr];

    // event detection
    wire logic cmp_changed = comparator_out != comparator_prev;
    wire logic ccp_event   = (ccp_mode == CFSR_CCP_CAPTURE & ccp_capture)
                           | (ccp_mode == CFSR_CCP_COMPARE & ccp_compare_match);

    // next flag values, set wins over a clearing write
    wire logic [7:0] next_flags = {
        set_wins(peripheral_event_flags[7], wr_flags, wbyte[7], eeprom_write_done),
        set_wins(peripheral_event_flags[6], wr_flags, wbyte[6], cmp_changed),
        rx_buffer_full,
        tx_buffer_empty,
        1'b0,
        set_wins(peripheral_event_flags[2], wr_flags, wbyte[2], ccp_event),
        set_wins(peripheral_event_flags[1], wr_flags, wbyte[1], timer2_match),
        set_wins(peripheral_event_flags[0], wr_flags, wbyte[0], timer1_overflow)
    };

    // power control read value
    wire logic [7:0] power_rdata = {4'h0, internal_osc_speed_select, 1'b0,
                                    power_on_status, brown_out_status};

    // program counter sequencing
    wire logic     do_push   = jump_call | irq_branch;
    wire cfsr_sp_t pop_ptr   = stack_ptr - 3'd1;
    wire cfsr_pc_t pc_next1  = program_counter + 13'd1;
    wire cfsr_pc_t push_val  = irq_branch ? program_counter : pc_next1;
    wire cfsr_pc_t jump_pc   = {program_counter_high_latch[4:3], jump_target};
    wire cfsr_pc_t pcl_pc    = {program_counter_high_latch[4:0], wbyte};
    wire cfsr_pc_t next_pc   = return_any            ? return_stack[pop_ptr] :
                               irq_branch            ? `CFSR_IRQ_VECTOR :
                               (jump_call|jump_goto) ? jump_pc :
                               wr_pcl                ? pcl_pc :
                               pc_advance            ? pc_next1 : program_counter;

    // read mux
    wire logic [7:0] rd_byte = hit_ind   ? ind_rdata :
                               hit_pcl   ? program_counter[7:0] :
                               hit_bank  ? {indirect_bank_bit, 7'h00} :
                               hit_fsr   ? file_pointer :
                               hit_latch ? {3'h0, program_counter_high_latch[4:0]} :
                               hit_flags ? peripheral_event_flags :
                               hit_power ? power_rdata : 8'h00;

    // apb answer, one wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready  <= 1'b0;
            prdata  <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            pready  <= bus_access & ~pready;
            prdata  <= (bus_access & ~pready & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
            pslverr <= bus_access & ~pready & ~hit_any;
        end
    end

    // flags and control
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            peripheral_event_flags     <= `CFSR_FLAGS_RESET;
            comparator_prev            <= 1'b0;
            internal_osc_speed_select  <= `CFSR_OSC_RESET;
            program_counter_high_latch <= 8'h00;
            file_pointer               <= 8'h00;
            indirect_bank_bit          <= 1'b0;
            cause_pending              <= 1'b1;
        end else begin
            peripheral_event_flags <= next_flags;
            comparator_prev        <= comparator_out;
            cause_pending          <= 1'b0;
            if (wr_power) begin
                internal_osc_speed_select <= wbyte[`CFSR_BIT_OSC_SPEED];
            end
            if (wr_fire & hit_latch) begin
                program_counter_high_latch <= {3'h0, wbyte[4:0]};
            end
            if (wr_fire & hit_fsr) begin
                file_pointer <= wbyte;
            end
            if (wr_fire & hit_bank) begin
                indirect_bank_bit <= wbyte[`CFSR_BIT_BANK];
            end
        end
    end

    // power-on reset clears both cause bits, an enabled brown-out reset clears the brown-out bit, other resets keep them
    always_ff @(posedge pclk) begin
        if (cause_pending & reset_was_por) begin
            power_on_status  <= 1'b0;
            brown_out_status <= 1'b0;
        end else if (cause_pending & reset_was_bor & brown_out_enable_config) begin
            brown_out_status <= 1'b0;
        end else if (wr_power) begin
            power_on_status  <= wbyte[`CFSR_BIT_POWER_ON];
            brown_out_status <= wbyte[`CFSR_BIT_BROWN_OUT];
        end
    end

    // program counter and stack pointer
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            program_counter <= `CFSR_PC_RESET;
            stack_ptr       <= 3'd0;
        end else begin
            program_counter <= next_pc;
            if (return_any) begin
                stack_ptr <= pop_ptr;
            end else if (do_push) begin
                stack_ptr <= stack_ptr + 3'd1;
            end
        end
    end

    // stack storage, pointer wraps so the ninth push lands on the first
    always_ff @(posedge pclk) begin
        if (do_push & ~return_any) begin
            return_stack[stack_ptr] <= push_val;
        end
    end

    // data locations reached through the indirect port
    always_ff @(posedge pclk) begin
        if (wr_fire & hit_ind & ~ind_self) begin
            data_mem[ind_addr] <= wbyte;
        end
    end

    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    timer1_set_a: assert property (
        timer1_overflow |=> peripheral_event_flags[`CFSR_BIT_TIMER1])
        else $error("timer 1 flag not set");

    timer2_set_a: assert property (
        timer2_match |=> peripheral_event_flags[`CFSR_BIT_TIMER2])
        else $error("timer 2 flag not set");

    eeprom_set_a: assert property (
        eeprom_write_done && wr_flags |=> peripheral_event_flags[`CFSR_BIT_EEPROM])
        else $error("eeprom flag lost to clear");

    comparator_set_a: assert property (
        comparator_out != comparator_prev |=> peripheral_event_flags[`CFSR_BIT_COMPARATOR])
        else $error("comparator change missed");

    serial_mirror_a: assert property (
        peripheral_event_flags[`CFSR_BIT_SERIAL_RX] == $past(rx_buffer_full)
        && peripheral_event_flags[`CFSR_BIT_SERIAL_TX] == $past(tx_buffer_empty))
        else $error("serial flags not tracking buffers");

    ccp_pwm_a: assert property (
        ccp_mode == CFSR_CCP_PWM && !peripheral_event_flags[`CFSR_BIT_CCP] && !wr_flags
        |=> !peripheral_event_flags[`CFSR_BIT_CCP])
        else $error("ccp flag set in pwm mode");

    unused_zero_a: assert property (
        peripheral_event_flags[3] == 1'b0 && power_rdata[7:4] == 4'h0)
        else $error("unimplemented bit not zero");

    pcl_write_a: assert property (
        wr_pcl && !return_any && !do_push && !jump_goto
        |=> program_counter == {$past(program_counter_high_latch[4:0]), $past(wbyte)})
        else $error("pc low write did not load upper bits");

    call_load_a: assert property (
        jump_call && !return_any && !irq_branch
        |=> program_counter[12:11] == $past(program_counter_high_latch[4:3])
            && stack_ptr == $past(stack_ptr) + 3'd1)
        else $error("call did not load pc or push");

    pop_latch_a: assert property (
        return_any && !wr_fire
        |=> program_counter_high_latch == $past(program_counter_high_latch)
            && stack_ptr == $past(pop_ptr))
        else $error("return disturbed latch or pointer");

    indirect_self_a: assert property (
        bus_access && !pready && !pwrite && hit_ind && ind_self
        |=> pready && prdata == 32'h0000_0000)
        else $error("indirect self read not zero");

    ccp_capture_a: assert property (
        ccp_mode == CFSR_CCP_CAPTURE && ccp_capture |=> peripheral_event_flags[`CFSR_BIT_CCP])
        else $error("capture did not set ccp flag");

    ccp_compare_a: assert property (
        ccp_mode == CFSR_CCP_COMPARE && ccp_compare_match
        |=> peripheral_event_flags[`CFSR_BIT_CCP])
        else $error("compare match did not set ccp flag");

    sticky_flags_a: assert property (
        !wr_flags |=> (~peripheral_event_flags & $past(peripheral_event_flags)
                       & `CFSR_FLAGS_WMASK) == 8'h00)
        else $error("event flag dropped without a write");

    flag_write_a: assert property (
        wr_flags && !eeprom_write_done && !cmp_changed && !ccp_event
        && !timer2_match && !timer1_overflow
        |=> (peripheral_event_flags & `CFSR_FLAGS_WMASK)
            == ($past(wbyte) & `CFSR_FLAGS_WMASK))
        else $error("flag write not stored");

    readonly_bits_a: assert property (
        wr_flags |=> peripheral_event_flags[`CFSR_BIT_SERIAL_RX] == $past(rx_buffer_full)
            && peripheral_event_flags[3] == 1'b0)
        else $error("read-only flag bit took a write");

    osc_write_a: assert property (
        wr_power |=> internal_osc_speed_select == $past(wbyte[`CFSR_BIT_OSC_SPEED]))
        else $error("oscillator speed bit not written");

    por_clear_a: assert property (
        cause_pending && reset_was_por |=> !power_on_status)
        else $error("power-on status not cleared");

    bor_clear_a: assert property (
        cause_pending && reset_was_bor && brown_out_enable_config |=> !brown_out_status)
        else $error("brown-out status not cleared");

    pc_reset_a: assert property (@(posedge pclk) disable iff (1'b0)
        !presetn |-> program_counter == `CFSR_PC_RESET)
        else $error("pc not cleared in reset");

    advance_a: assert property (
        pc_advance && !return_any && !do_push && !jump_goto && !wr_pcl
        |=> program_counter == $past(program_counter) + 13'd1)
        else $error("pc did not advance");

    goto_load_a: assert property (
        jump_goto && !return_any && !do_push
        |=> program_counter == {$past(program_counter_high_latch[4:3]), $past(jump_target)}
            && stack_ptr == $past(stack_ptr))
        else $error("goto did not load pc");

    irq_push_a: assert property (
        irq_branch && !return_any
        |=> program_counter == `CFSR_IRQ_VECTOR && stack_ptr == $past(stack_ptr) + 3'd1)
        else $error("interrupt branch did not push");

    indirect_write_a: assert property (
        wr_fire && hit_ind && !ind_self |=> data_mem[$past(ind_addr)] == $past(wbyte))
        else $error("indirect write not stored");

    power_read_a: assert property (
        bus_access && !pready && !pwrite && hit_power
        |=> pready && prdata[7:4] == 4'h0 && prdata[2] == 1'b0)
        else $error("unused power bits not zero");

endmodule : cfsr_regs
`default_nettype wire

// ==== test/testbench.sv ====
`include "cfsr_cfg.svh"
`default_nettype none
`define CHK(got, exp) begin n_tests++; if ((got) !== (exp)) begin num_errors++; \
    $display("CHECK FAILED time=%0t got=%h exp=%h", $time, got, exp); end end
module testbench
    import cfsr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [9:0] P_EE = 10'h001, P_T2 = 10'h002, P_T1 = 10'h004, P_CAP = 10'h008;
    localparam logic [9:0] P_CMP = 10'h010, P_ADV = 10'h020, P_CALL = 10'h040;
    localparam logic [9:0] P_GOTO = 10'h080, P_IRQ = 10'h100, P_RET = 10'h200;
    logic           pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic [11:0]    paddr;
    logic [31:0]    pwdata, prdata, rd;
    logic           por_cause, bor_cause, comparator_out, rx_full, tx_empty, osc_sel;
    cfsr_ccp_mode_t ccp_mode;
    logic [10:0]    jump_target;
    logic [9:0]     pulses;
    cfsr_pc_t       program_counter;
    logic [7:0]     flags;
    int             num_errors, n_tests, i;

    cfsr_regs i_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata),
        .pslverr(pslverr), .reset_was_por(por_cause), .reset_was_bor(bor_cause),
        .brown_out_enable_config(1'b1), .eeprom_write_done(pulses[0]),
        .comparator_out(comparator_out), .rx_buffer_full(rx_full), .tx_buffer_empty(tx_empty),
        .ccp_mode(ccp_mode), .ccp_capture(pulses[3]), .ccp_compare_match(pulses[4]),
        .timer2_match(pulses[1]), .timer1_overflow(pulses[2]), .pc_advance(pulses[5]),
        .jump_call(pulses[6]), .jump_goto(pulses[7]), .jump_target(jump_target),
        .irq_branch(pulses[8]), .return_any(pulses[9]), .program_counter(program_counter),
        .internal_osc_speed_select(osc_sel), .peripheral_event_flags(flags));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task conclude;
        if (num_errors == 0 && n_tests > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : conclude

    // one apb transfer, held until pready is seen high at a rising edge
    task apb(input logic w, input logic [9:0] idx, input logic [7:0] d);
        int n;
        n = 0;
        @(posedge pclk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= w;
        paddr   <= {idx, 2'b00};
        pwdata  <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (pready !== 1'b1) begin
            num_errors++;
            conclude();
        end
        rd      = prdata;
        err     = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task rchk(input logic [9:0] idx, input logic [7:0] exp);
        apb(1'b0, idx, 8'h00);
        `CHK(rd, {24'h000000, exp})
    endtask : rchk

    task ev(input logic [9:0] m, input logic [10:0] t);
        @(posedge pclk);
        pulses      <= m;
        jump_target <= t;
        @(posedge pclk);
        pulses <= 10'h000;
    endtask : ev

    task pchk(input cfsr_pc_t e);
        @(negedge pclk);
        `CHK(program_counter, e)
    endtask : pchk

    initial begin
        repeat (30000) @(posedge pclk);
        num_errors++;
        conclude();
    end

    initial begin
        {presetn, psel, penable, pwrite, paddr, pwdata} = '0;
        {comparator_out, rx_full, tx_empty, pulses, jump_target, bor_cause} = '0;
        por_cause = 1'b1;
        ccp_mode  = CFSR_CCP_CAPTURE;
        num_errors = 0;
        n_tests    = 0;
        repeat (6) @(posedge pclk);
        presetn <= 1'b1;
        pchk(13'h0000);
        `CHK(osc_sel, 1'b1)
        rchk(`CFSR_IDX_FLAGS, 8'h00);
        rchk(`CFSR_IDX_POWER, 8'h08);
        apb(1'b1, `CFSR_IDX_POWER, 8'hFF);
        rchk(`CFSR_IDX_POWER, 8'h0B);
        apb(1'b1, `CFSR_IDX_POWER, 8'h03);
        @(negedge pclk);
        `CHK(osc_sel, 1'b0)
        apb(1'b1, `CFSR_IDX_POWER, 8'h0B);
        apb(1'b1, 10'h001, 8'hFF);
        `CHK(err, 1'b1)
        rchk(10'h001, 8'h00);
        // every sticky event flag, with nothing enabled anywhere
        ev(P_EE | P_T2 | P_T1 | P_CAP, 11'h000);
        @(posedge pclk);
        comparator_out <= 1'b1;
        rchk(`CFSR_IDX_FLAGS, 8'hC7);
        rchk(`CFSR_IDX_FLAGS, 8'hC7);
        apb(1'b1, `CFSR_IDX_FLAGS, 8'h00);
        rchk(`CFSR_IDX_FLAGS, 8'h00);
        ccp_mode <= CFSR_CCP_COMPARE;
        ev(P_CMP, 11'h000);
        rchk(`CFSR_IDX_FLAGS, 8'h01 << `CFSR_BIT_CCP);
        apb(1'b1, `CFSR_IDX_FLAGS, 8'h00);
        ccp_mode <= CFSR_CCP_PWM;
        ev(P_CAP | P_CMP, 11'h000);
        rchk(`CFSR_IDX_FLAGS, 8'h00);
        @(posedge pclk);
        rx_full  <= 1'b1;
        tx_empty <= 1'b1;
        rchk(`CFSR_IDX_FLAGS, 8'h30);
        apb(1'b1, `CFSR_IDX_FLAGS, 8'hFF);
        rchk(`CFSR_IDX_FLAGS, 8'hF7);
        apb(1'b1, `CFSR_IDX_FLAGS, 8'h00);
        rx_full        <= 1'b0;
        tx_empty       <= 1'b0;
        comparator_out <= 1'b0;
        rchk(`CFSR_IDX_FLAGS, 8'h40);
        // eeprom event in the very cycle of a clearing write: the set wins
        fork
            apb(1'b1, `CFSR_IDX_FLAGS, 8'h00);
            begin
                repeat (3) @(posedge pclk);
                pulses <= P_EE;
                @(posedge pclk);
                pulses <= 10'h000;
            end
        join
        rchk(`CFSR_IDX_FLAGS, 8'h80);
        // program counter loading
        apb(1'b1, `CFSR_IDX_PC_LATCH, 8'h1F);
        apb(1'b1, `CFSR_IDX_PC_LOW, 8'h34);
        pchk(13'h1F34);
        rchk(`CFSR_IDX_PC_LOW, 8'h34);
        ev(P_CALL, 11'h123);
        pchk(13'h1923);
        ev(P_RET, 11'h000);
        pchk(13'h1F35);
        rchk(`CFSR_IDX_PC_LATCH, 8'h1F);
        ev(P_GOTO, 11'h456);
        pchk(13'h1C56);
        ev(P_ADV, 11'h000);
        ev(P_IRQ, 11'h000);
        pchk(`CFSR_IRQ_VECTOR);
        ev(P_RET, 11'h000);
        pchk(13'h1C57);
        // nine pushes wrap over the first entry
        apb(1'b1, `CFSR_IDX_PC_LATCH, 8'h00);
        apb(1'b1, `CFSR_IDX_PC_LOW, 8'h00);
        pchk(13'h0000);
        for (i = 1; i <= 9; i++) begin
            ev(P_CALL, 11'(i * 16));
        end
        for (i = 0; i < 8; i++) begin
            ev(P_RET, 11'h000);
            pchk(cfsr_pc_t'(13'h081 - 13'(i * 16)));
        end
        ev(P_RET, 11'h000);
        pchk(13'h0081);
        // indirect access through the 9-bit pointer
        apb(1'b1, `CFSR_IDX_BANK_CTRL, 8'h00);
        apb(1'b1, `CFSR_IDX_FILE_PTR, 8'h20);
        apb(1'b1, `CFSR_IDX_INDIRECT, 8'h5A);
        apb(1'b1, `CFSR_IDX_BANK_CTRL, 8'h01 << `CFSR_BIT_BANK);
        apb(1'b1, `CFSR_IDX_INDIRECT, 8'h3C);
        rchk(`CFSR_IDX_INDIRECT, 8'h3C);
        apb(1'b1, `CFSR_IDX_BANK_CTRL, 8'h00);
        rchk(`CFSR_IDX_INDIRECT, 8'h5A);
        apb(1'b1, `CFSR_IDX_FILE_PTR, 8'h00);
        apb(1'b1, `CFSR_IDX_INDIRECT, 8'h77);
        rchk(`CFSR_IDX_INDIRECT, 8'h00);
        // brown-out reset in mid-run
        apb(1'b1, `CFSR_IDX_POWER, 8'h0B);
        @(posedge pclk);
        presetn   <= 1'b0;
        por_cause <= 1'b0;
        bor_cause <= 1'b1;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        pchk(13'h0000);
        rchk(`CFSR_IDX_POWER, 8'h0A);
        rchk(`CFSR_IDX_FLAGS, 8'h00);
        conclude();
    end
endmodule : testbench
`default_nettype wire
